// File: aem_map.vh
`ifndef AEM_MAP_VH
`define AEM_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// clock
`define AEM_CLK_HZ      250000000
`define AEM_CLK_NS      4

////////////////////////////////////////////////////////////////////////////////
// serial character timing: 9600 bps, bit time rounded down to whole cycles
`define AEM_BAUD        9600
// 250 MHz over 9600 bps is 26041 cycles a bit
`define AEM_BIT_CYC     16'h65B9
// start + 7 data + parity + stop
`define AEM_CHAR_BITS   4'hA
// bytes in one revolution-count message
`define AEM_NUM_BYTES   4'h8

////////////////////////////////////////////////////////////////////////////////
// settle time after the last serial byte, in ms
`define AEM_SETTLE_MS   50
// 50 ms of the 250 MHz clock, sized to the settle timer
`define AEM_SETTLE_CYC  24'hBEBC20
// least time of one quadrature step of the initial pulses, in ns, rounded up
`define AEM_STEP_NS     400
// 400 ns at 4 ns a cycle, sized to the step parameter
`define AEM_STEP_CYC    16'h0064

////////////////////////////////////////////////////////////////////////////////
// revolution count limits and reset value
`define AEM_CNT_MAX     16'h7FFF
`define AEM_CNT_MIN     16'h8000
`define AEM_CNT_RST     16'h0000

////////////////////////////////////////////////////////////////////////////////
// encoder usage setting codes, factory default absolute
`define AEM_USE_ABS     1'b0
`define AEM_USE_INC     1'b1

////////////////////////////////////////////////////////////////////////////////
// message characters
`define AEM_CH_HEAD     7'h50
`define AEM_CH_PLUS     7'h2B
`define AEM_CH_MINUS    7'h2D
`define AEM_CH_END      7'h0D
`define AEM_CH_DIGIT    3'h3

`endif

// File: aem_char_tx.v
`include "aem_map.vh"

// one asynchronous character: start, 7 data lsb first, even parity, stop
module aem_char_tx #(
	parameter [15:0] BIT_CYC = 16'h65B9
) (
	// clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// character request
	input  wire       start,
	input  wire [6:0] data,
	output reg        busy,
	// serial line, idle high
	output reg        line
);

	reg [9:0]  shift_q;   // frame bits still to send
	reg [3:0]  bits_q;    // bits left in frame
	reg [15:0] tick_q;    // cycles into current bit

	////////////////////////////////////////////////////////////////////////////////
	// bit shifter; start is ignored while busy
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_q <= 10'h3FF;
			bits_q  <= 4'h0;
			tick_q  <= 16'h0000;
			busy    <= 1'b0;
			line    <= 1'b1;
		end
		else if (!busy)
		begin
			line <= 1'b1;
			if (start)
			begin
				// stop, even parity, data, start
				shift_q <= {1'b1, ^data, data, 1'b0};
				bits_q  <= `AEM_CHAR_BITS;
				tick_q  <= 16'h0000;
				busy    <= 1'b1;
			end
		end
		else
		begin
			line <= shift_q[0];
			if (tick_q == BIT_CYC - 16'h0001)
			begin
				tick_q  <= 16'h0000;
				shift_q <= {1'b1, shift_q[9:1]};
				bits_q  <= bits_q - 4'h1;
				// frame ends after the stop bit time
				if (bits_q == 4'h1)
					busy <= 1'b0;
			end
			else
				tick_q <= tick_q + 16'h0001;
		end
	end

endmodule

// File: aem_top.v
`include "aem_map.vh"

// Summary of operation
// [R1] positive overflow past +32767 wraps to -32768
// [R2] negative overflow past -32768 wraps to +32767
// [R3] host waits three seconds before raising request
// [R4] request rising edge starts data then pulses
// [R5] motor held off until transfer finishes
// [R6] host holds request 1.3 s before toggling
// [R7] usage setting: 0 absolute, 1 incremental
// [R8] usage setting takes effect after power cycle
// [R9] revolution count kept on backup supply
// [R10] host holds request low 15 ms
// [R11] host clears counter, waits for serial
// [R12] message is eight serial bytes
// [R13] normal pulses resume 50 ms after last byte; code waits 50 ms after the last initial pulse
// [R14] five ascii digits, 9600 7E1 async
module aem_top #(
	parameter [15:0] BIT_CYC    = `AEM_BIT_CYC,
	parameter [23:0] SETTLE_CYC = `AEM_SETTLE_CYC,
	parameter [15:0] STEP_CYC   = `AEM_STEP_CYC
) (
	// main and backup clocking
	input  wire        clk,
	input  wire        rst_n,
	input  wire        bkp_rst_n,
	// host pins
	input  wire        position_request_line,
	output reg         phase_a_serial_output,
	output reg         phase_b_output,
	// setting and drive pins
	input  wire        encoder_usage_select,
	input  wire        drive_energize,
	output reg         motor_enable,
	output reg         transfer_busy,
	// encoder side pins
	input  wire        enc_a,
	input  wire        enc_b,
	input  wire        rev_step,
	input  wire        rev_dir,
	input  wire [15:0] init_pulse_count,
	output reg  [15:0] rev_count
);

	localparam [4:0] ST_IDLE   = 5'h01;  // waiting for first request
	localparam [4:0] ST_SEND   = 5'h02;  // serial message
	localparam [4:0] ST_PULSE  = 5'h04;  // initial incremental pulses
	localparam [4:0] ST_SETTLE = 5'h08;  // gap before normal output
	localparam [4:0] ST_NORM   = 5'h10;  // normal incremental output

	reg [1:0]  req_sy_q;     // request synchroniser
	reg        req_old_q;    // request of previous cycle
	reg [1:0]  use_sy_q;     // usage setting synchroniser
	reg [1:0]  en_sy_q;      // energize synchroniser
	reg [1:0]  a_sy_q;       // phase a synchroniser
	reg [1:0]  b_sy_q;       // phase b synchroniser
	reg [1:0]  stp_sy_q;     // revolution step synchroniser
	reg [1:0]  dir_sy_q;     // revolution direction synchroniser
	reg        stp_old_q;    // step of previous cycle
	reg [1:0]  lat_cnt_q;    // cycles since reset release
	reg        latched_q;    // usage setting captured
	reg        use_q;        // usage in force until power cycle
	reg [4:0]  state_q;      // sequence state
	reg [3:0]  byte_q;       // next message byte
	reg        tx_start_q;   // character request pulse
	reg [6:0]  tx_data_q;    // character to send
	reg [16:0] mag_q;        // magnitude snapshot of the count
	reg        neg_q;        // sign snapshot of the count
	reg [15:0] pulses_q;     // initial pulses still to send
	reg [1:0]  quad_q;       // quadrature step
	reg [23:0] timer_q;      // step and settle timer
	wire       tx_busy;      // character in flight
	wire       tx_line;      // serial line from shifter
	wire       req_rise;     // request rising edge
	wire       stp_rise;     // one revolution passed
	wire [16:0] dig_4;
	wire [16:0] dig_3;
	wire [16:0] dig_2;
	wire [16:0] dig_1;
	wire [16:0] dig_0;

	assign req_rise = req_sy_q[1] & ~req_old_q;
	assign stp_rise = stp_sy_q[1] & ~stp_old_q;
	// decimal digits of the snapshot, most significant first
	assign dig_4 = (mag_q / 17'h02710) % 17'h0000A;  // [R14]
	assign dig_3 = (mag_q / 17'h003E8) % 17'h0000A;
	assign dig_2 = (mag_q / 17'h00064) % 17'h0000A;
	assign dig_1 = (mag_q / 17'h0000A) % 17'h0000A;
	assign dig_0 = mag_q % 17'h0000A;

	////////////////////////////////////////////////////////////////////////////////
	// main-domain pin synchronisers, only the second stage is read
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_sy_q  <= 2'h0;
			req_old_q <= 1'b0;
			use_sy_q  <= 2'h0;
			en_sy_q   <= 2'h0;
			a_sy_q    <= 2'h0;
			b_sy_q    <= 2'h0;
		end
		else
		begin
			req_sy_q  <= {req_sy_q[0], position_request_line};
			req_old_q <= req_sy_q[1];
			use_sy_q  <= {use_sy_q[0], encoder_usage_select};
			en_sy_q   <= {en_sy_q[0], drive_energize};
			a_sy_q    <= {a_sy_q[0], enc_a};
			b_sy_q    <= {b_sy_q[0], enc_b};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// usage setting: caught once after release, once the synchroniser has
	// filled; later changes on the pin are ignored until the next power-up
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lat_cnt_q <= 2'h0;
			latched_q <= 1'b0;
			use_q     <= `AEM_USE_ABS;  // [R7]
		end
		else if (!latched_q)
		begin
			lat_cnt_q <= lat_cnt_q + 2'h1;
			if (lat_cnt_q == 2'h3)
			begin
				latched_q <= 1'b1;
				use_q     <= use_sy_q[1];  // [R8]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// revolution count lives on the backup reset so a main power loss keeps it
	always @(posedge clk or negedge bkp_rst_n)
	begin
		if (!bkp_rst_n)
		begin
			stp_sy_q  <= 2'h0;
			dir_sy_q  <= 2'h0;
			stp_old_q <= 1'b0;
			rev_count <= `AEM_CNT_RST;  // [R9]
		end
		else
		begin
			stp_sy_q  <= {stp_sy_q[0], rev_step};
			dir_sy_q  <= {dir_sy_q[0], rev_dir};
			stp_old_q <= stp_sy_q[1];
			if (stp_rise)
			begin
				if (!dir_sy_q[1])
				begin
					// positive turn
					if (rev_count == `AEM_CNT_MAX)
						rev_count <= `AEM_CNT_MIN;  // [R1]
					else
						rev_count <= rev_count + 16'h0001;
				end
				else
				begin
					// negative turn
					if (rev_count == `AEM_CNT_MIN)
						rev_count <= `AEM_CNT_MAX;  // [R2]
					else
						rev_count <= rev_count - 16'h0001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transfer sequence; a new rising edge restarts from the message even
	// mid-transfer, so a host that toggles early gets a fresh snapshot
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q    <= ST_IDLE;
			byte_q     <= 4'h0;
			tx_start_q <= 1'b0;
			tx_data_q  <= 7'h00;
			mag_q      <= 17'h00000;
			neg_q      <= 1'b0;
			pulses_q   <= 16'h0000;
			quad_q     <= 2'h0;
			timer_q    <= 24'h000000;
		end
		else
		begin
			tx_start_q <= 1'b0;
			if (latched_q && use_q == `AEM_USE_INC)
				state_q <= ST_NORM;  // [R7]
			else if (latched_q && req_rise)
			begin
				// snapshot count and pulse offset at the edge
				state_q  <= ST_SEND;  // [R4]
				byte_q   <= 4'h0;
				neg_q    <= rev_count[15];
				mag_q    <= rev_count[15] ? (17'h10000 - {1'b0, rev_count})
					: {1'b0, rev_count};
				pulses_q <= init_pulse_count;
				quad_q   <= 2'h0;
				timer_q  <= 24'h000000;
			end
			else
			begin
				case (state_q)
					ST_SEND:
					begin
						// next byte once the shifter is free
						if (!tx_start_q && !tx_busy)
						begin
							if (byte_q == `AEM_NUM_BYTES)  // [R12]
								state_q <= ST_PULSE;  // [R4]
							else
							begin
								tx_start_q <= 1'b1;
								byte_q     <= byte_q + 4'h1;
								case (byte_q)
									4'h0:    tx_data_q <= `AEM_CH_HEAD;
									4'h1:    tx_data_q <= neg_q ? `AEM_CH_MINUS : `AEM_CH_PLUS;
									4'h2:    tx_data_q <= {`AEM_CH_DIGIT, dig_4[3:0]};  // [R14]
									4'h3:    tx_data_q <= {`AEM_CH_DIGIT, dig_3[3:0]};
									4'h4:    tx_data_q <= {`AEM_CH_DIGIT, dig_2[3:0]};
									4'h5:    tx_data_q <= {`AEM_CH_DIGIT, dig_1[3:0]};
									4'h6:    tx_data_q <= {`AEM_CH_DIGIT, dig_0[3:0]};
									default: tx_data_q <= `AEM_CH_END;
								endcase
							end
						end
					end
					ST_PULSE:
					begin
						// one quadrature cycle of four steps per pulse
						if (pulses_q == 16'h0000)
						begin
							state_q <= ST_SETTLE;
							timer_q <= 24'h000000;
						end
						else if (timer_q == {8'h00, STEP_CYC} - 24'h000001)
						begin
							timer_q <= 24'h000000;
							quad_q  <= quad_q + 2'h1;
							if (quad_q == 2'h3)
								pulses_q <= pulses_q - 16'h0001;
						end
						else
							timer_q <= timer_q + 24'h000001;
					end
					ST_SETTLE:
					begin
						if (timer_q == SETTLE_CYC - 24'h000001)
							state_q <= ST_NORM;  // [R13]
						else
							timer_q <= timer_q + 24'h000001;
					end
					ST_IDLE:
						state_q <= ST_IDLE;
					ST_NORM:
						state_q <= ST_NORM;
					default:
						state_q <= ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered outputs: line source per state, motor gate
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_a_serial_output <= 1'b1;
			phase_b_output        <= 1'b0;
			motor_enable          <= 1'b0;
			transfer_busy         <= 1'b0;
		end
		else
		begin
			transfer_busy <= (state_q == ST_SEND) | (state_q == ST_PULSE);
			// energize is ignored until the pulses have gone out
			motor_enable  <= en_sy_q[1] & ((state_q == ST_SETTLE) | (state_q == ST_NORM));  // [R5]
			case (state_q)
				ST_SEND:
				begin
					phase_a_serial_output <= tx_line;  // [R14]
					phase_b_output        <= 1'b0;
				end
				ST_PULSE:
				begin
					phase_a_serial_output <= quad_q[1];
					phase_b_output        <= quad_q[1] ^ quad_q[0];
				end
				ST_NORM:
				begin
					phase_a_serial_output <= a_sy_q[1];
					phase_b_output        <= b_sy_q[1];
				end
				default:
				begin
					// idle high mark on the serial phase
					phase_a_serial_output <= 1'b1;
					phase_b_output        <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// character shifter
	aem_char_tx #(
		.BIT_CYC (BIT_CYC)
	) u_char_tx (
		.clk   (clk),
		.rst_n (rst_n),
		.start (tx_start_q),
		.data  (tx_data_q),
		.busy  (tx_busy),
		.line  (tx_line)
	);

endmodule

// File: aem_props.sv
// watches the top ports: count wrap, retention, request answer, motor lockout
module aem_props (
	// clock and resets
	input wire        clk,
	input wire        rst_n,
	input wire        bkp_rst_n,
	// host and drive pins
	input wire        position_request_line,
	input wire        phase_a_serial_output,
	input wire        encoder_usage_select,
	input wire        drive_energize,
	input wire        motor_enable,
	input wire        transfer_busy,
	// revolution count
	input wire        rev_step,
	input wire [15:0] rev_count
);
	timeunit 1ns;
	timeprecision 1ps;

	reg  [3:0] up_q;   // edges since power-on, saturating
	reg        mode_q; // usage level once the design has taken it
	wire       live = (up_q == 4'hF);

	////////////////////////////////////////////////////////////////////////
	// power-on bookkeeping; the pin is steady around the latch edge
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			up_q   <= 4'h0;
			mode_q <= 1'b0;
		end
		else
		begin
			if (!live)
				up_q <= up_q + 4'h1;
			if (up_q == 4'h6)
				mode_q <= encoder_usage_select;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	wrap_top_a: assert property (disable iff (!bkp_rst_n)
		$past(rev_count) == 16'h7FFF && $changed(rev_count)
		|-> rev_count inside {16'h8000, 16'h7FFE}) else $error("bad step from top");
	wrap_bottom_a: assert property (disable iff (!bkp_rst_n)
		$past(rev_count) == 16'h8000 && $changed(rev_count)
		|-> rev_count inside {16'h7FFF, 16'h8001}) else $error("bad step from bottom");
	count_retain_a: assert property (disable iff (!bkp_rst_n)
		!rev_step [*5] ##1 !rst_n |-> $stable(rev_count)) else $error("count lost in reset");
	req_answer_a: assert property (
		$rose(position_request_line) && live && !mode_q |-> ##[1:6] transfer_busy)
		else $error("request not answered");
	start_bit_a: assert property (
		$rose(transfer_busy) |-> ##[1:4] !phase_a_serial_output) else $error("no start bit");
	motor_lock_a: assert property (
		transfer_busy |-> !motor_enable) else $error("motor on in transfer");
	inc_quiet_a: assert property (
		live && mode_q |-> !transfer_busy) else $error("transfer in incremental use");
	inc_motor_a: assert property (
		live && mode_q && drive_energize [*4] |-> motor_enable) else $error("motor held off");

	cover property ($fell(transfer_busy));
	cover property (live && mode_q && motor_enable);
	cover property (disable iff (!bkp_rst_n) $past(rev_count) == 16'h8000 && rev_count == 16'h7FFF);
endmodule

bind aem_top aem_props u_props (
	.clk                   (clk),
	.rst_n                 (rst_n),
	.bkp_rst_n             (bkp_rst_n),
	.position_request_line (position_request_line),
	.phase_a_serial_output (phase_a_serial_output),
	.encoder_usage_select  (encoder_usage_select),
	.drive_energize        (drive_energize),
	.motor_enable          (motor_enable),
	.transfer_busy         (transfer_busy),
	.rev_step              (rev_step),
	.rev_count             (rev_count)
);

// File: aem_host_model.sv
// host side: raises the request, reads 7E1 characters, counts B cycles
module aem_host_model #(
	parameter int BIT_CYC = 16
) (
	// clock
	input wire   clk,
	// drive outputs
	input wire   line,
	input wire   quad_b,
	// request to the drive
	output logic req
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [63:0] msg;    // characters, newest in the low byte
	logic [9:0]  fr;     // one received frame
	logic        armed;  // a request has been raised
	logic        b_q;    // phase b one edge ago
	int          n_char; // characters taken
	int          n_err;  // framing or parity faults
	int          n_step; // quadrature cycles seen

	// drop, hold low, raise; times are scaled down from the real host
	task automatic ask();
		@(posedge clk);
		#1 req = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		n_char = 0;
		n_step = 0;
		msg = '0;
		armed = 1'b1;
		req = 1'b1;
	endtask

	////////////////////////////////////////////////////////////////////////
	// receiver samples mid-bit, re-syncing on every start edge
	initial
	begin
		req = 1'b0;
		armed = 1'b0;
		n_char = 0;
		n_err = 0;
		n_step = 0;
		msg = '0;
		forever
		begin
			// look a little after the edge, once the registered line has settled
			@(posedge clk);
			#1;
			if (armed && n_char < 8 && line === 1'b0)
			begin
				repeat (BIT_CYC / 2) @(posedge clk);
				#1 fr[0] = line;
				for (int i = 1; i < 10; i++)
				begin
					repeat (BIT_CYC) @(posedge clk);
					#1 fr[i] = line;
				end
				if (fr[0] !== 1'b0 || fr[9] !== 1'b1 || ^fr[8:1] !== 1'b0)
					n_err++;
				msg = {msg[55:0], 1'b0, fr[7:1]};
				n_char++;
			end
		end
	end

	// initial pulses: one rise of b per quadrature cycle after the message
	always @(posedge clk)
	begin
		b_q <= quad_b;
		if (n_char == 8 && quad_b === 1'b1 && b_q === 1'b0)
			n_step <= n_step + 1;
	end
endmodule

// File: aem_top_test.sv
module aem_top_test;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int SETTLE = 50; // shortened settle count

	logic        clk, rst_n, bkp_rst_n, req, pa, pb;
	logic        use_sel, energize, motor, busy;
	logic        enc_a, enc_b, rev_step, rev_dir;
	logic [15:0] init_cnt, rev_count;
	int          n_mismatch, num_checks;

	aem_top #(
		.BIT_CYC    (16'h0010),
		.SETTLE_CYC (24'h000032),
		.STEP_CYC   (16'h0002)
	) u_dut (
		.clk (clk), .rst_n (rst_n), .bkp_rst_n (bkp_rst_n),
		.position_request_line (req), .phase_a_serial_output (pa), .phase_b_output (pb),
		.encoder_usage_select (use_sel), .drive_energize (energize),
		.motor_enable (motor), .transfer_busy (busy), .enc_a (enc_a), .enc_b (enc_b),
		.rev_step (rev_step), .rev_dir (rev_dir), .init_pulse_count (init_cnt),
		.rev_count (rev_count)
	);

	aem_host_model #(
		.BIT_CYC (16)
	) u_host (
		.clk (clk), .line (pa), .quad_b (pb), .req (req)
	);

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		num_checks++;
		if (seen !== want)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, seen, want);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// bounded wait on busy; running out ends the run
	task automatic wait_busy(input logic lvl, input int lim);
		for (int i = 0; i < lim && busy !== lvl; i++)
			tick(1);
		if (busy !== lvl)
		begin
			n_mismatch++;
			$display("wrong value at %0t: busy wait ran out", $time);
			conclude();
		end
	endtask

	// main reset only; the count rides on the backup domain
	task automatic power(input logic sel);
		rst_n = 1'b0;
		use_sel = sel;
		tick(5);
		check({pa, pb, motor, busy}, 4'h8);
		rst_n = 1'b1;
		tick(10);
	endtask

	task automatic step(input logic dir, input int n);
		rev_dir = dir;
		repeat (n)
		begin
			rev_step = 1'b1;
			tick(1);
			rev_step = 1'b0;
			tick(1);
		end
		tick(4);
	endtask

	// one request: message, pulses, lockout, settle gap, then pass-through
	task automatic xfer(input logic [7:0] sign, input logic [39:0] digs, input logic [15:0] np);
		init_cnt = np;
		u_host.ask();
		wait_busy(1'b1, 10);
		check(motor, 1'b0);
		wait_busy(1'b0, 2000 + 16 * np);
		check(u_host.n_char, 8);
		check(u_host.n_err, 0);
		check(u_host.msg, {8'h50, sign, digs, 8'h0D});
		check(u_host.n_step, np);
		// encoder phases move inside the settle gap and must not show yet
		enc_a = 1'b0;
		enc_b = 1'b1;
		tick(SETTLE - 10);
		check({pa, pb}, 2'h2);
		check(motor, 1'b1);
		tick(20);
		check({pa, pb}, 2'h1);
		enc_a = 1'b1;
		enc_b = 1'b0;
		tick(6);
	endtask

	// count down through the negative limit, then back over the positive one
	task automatic wrap_count();
		step(1'b1, 32768);
		check(rev_count, 16'h8000);
		step(1'b1, 1);
		check(rev_count, 16'h7FFF);
		step(1'b0, 1);
		check(rev_count, 16'h8000);
	endtask

	// a new usage level waits for power-up; the count survives the power-up
	task automatic inc_use();
		use_sel = 1'b1;
		xfer("-", "32768", 16'h0000);
		power(1'b1);
		check(rev_count, 16'h8000);
		u_host.ask();
		tick(40);
		check(busy, 1'b0);
		check(motor, 1'b1);
		energize = 1'b0;
		tick(4);
		check(motor, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		n_mismatch = 0;
		num_checks = 0;
		bkp_rst_n = 1'b0;
		energize = 1'b1;
		enc_a = 1'b1;
		enc_b = 1'b0;
		rev_step = 1'b0;
		rev_dir = 1'b0;
		init_cnt = 16'h0000;
		power(1'b0);
		bkp_rst_n = 1'b1;
		tick(2);
		xfer("+", "00000", 16'h0003);
		wrap_count();
		inc_use();
		conclude();
	end
endmodule
